/* design/ldk_pkg.sv */
package ldk_pkg;
   // command classes in the top two bits
   localparam logic [1:0] CMD_MODE = 2'b00;
   localparam logic [1:0] CMD_DATA = 2'b01;
   localparam logic [1:0] CMD_ADDR = 2'b11;
   localparam logic [1:0] CMD_CTRL = 2'b10;
   // display mode encodings in b1..b0
   localparam logic [1:0] MODE_6GRID = 2'b10;
   localparam logic [1:0] MODE_7GRID = 2'b11;
   localparam logic [1:0] MODE_RST = MODE_7GRID;
   // data setting option bits
   localparam int DSET_READ_BIT = 1;
   localparam int DSET_FIXED_BIT = 2;
   localparam logic [3:0] DSET_RST = 4'h0;
   // display control fields
   localparam int DCTL_ON_BIT = 3;
   localparam logic [2:0] DIM_RST = 3'h0;
   // display ram
   localparam int RAM_DEPTH = 14;
   localparam logic [3:0] ADDR_LAST = 4'hd;
   localparam logic [3:0] ADDR_RST = 4'h0;
   localparam int KEY_BYTES = 5;
   localparam int KEY_SRC = 10;
   // multiplex timing: one grid slot, 8 grid slots per display cycle
   localparam int SLOT_CYCLES = 1000;
   localparam int GRID_SLOTS = 8;
   localparam int DIM_STEPS = 16;
   // host read wait after command, in ns
   localparam int TWAIT_NS = 1000;
   localparam int CLK_NS = 20;
   localparam int TWAIT_CYC = (TWAIT_NS + CLK_NS - 1) / CLK_NS;
endpackage

/* design/ldk_sync.sv */
`timescale 1ns/100ps
// two-flop synchroniser for one pin
module ldk_sync (
   input wire logic clk,
   input wire logic d,
   output logic q
);
   logic meta_r;
   // first flop feeds only the second
   always_ff @(posedge clk) begin
      meta_r <= d;
      q <= meta_r;
   end
endmodule

/* design/ldk_ctrl.sv */
`timescale 1ns/100ps
// Operation
// - first byte after frame select falls is the command, b0 first.
// - frame select rising mid-byte resets receiver, drops partial byte.
// - shift clock ignored while frame select is high.
// - input sampled on rising shift clock edge, lsb first.
// - output changes on falling edge, open-drain, only pulls low.
// - mode command has b7..b2 zero; low bits pick 6 or 7 grids.
// - after mode change display stays dark until display-on command.
// - mode command repeating active mode does nothing.
// - power-up mode is seven grids, eleven segments.
// - data setting command is b7..b4 = 0100; picks write or read.
// - data setting option bits reset to zero.
// - read shifts key bytes lsb first, rolling into next byte.
// - key byte holds odd source in b0-b2, even in b3-b5.
// - key returns latched at end of each display cycle.
// - addresses 00h-0dh valid; higher address ignores data.
// - address pointer resets to zero.
// - ram is 14 bytes, two per grid digit: first byte whole, second byte b0-b3 only.
// - control command sets on/off and width; reset 1/16, off, scan on.
// - auto-increment write stores then advances, up to 14 bytes.
module ldk_ctrl
   import ldk_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic FRAME_SELECT,
   input wire logic SHIFT_CLK,
   input wire logic DATA_IN,
   output logic DATA_OUT_O,
   output logic DATA_OUT_OE,
   input wire logic [2:0] KEY_RETURN_LINES,
   output logic [9:0] SEGMENT_KEY_SOURCE_LINES,
   output logic SEGMENT_ELEVEN_LINE,
   output logic SHARED_SEGMENT_GRID_LINE,
   output logic [5:0] GRID_DRIVE_LINES,
   output logic DISPLAY_ON,
   output logic SIX_GRID_MODE
);
   import ldk_pkg::*;

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic stb_s, sck_s, din_s;
   logic [2:0] key_s;
   ldk_sync u_stb (.clk(SYS_CLK), .d(FRAME_SELECT), .q(stb_s));
   ldk_sync u_sck (.clk(SYS_CLK), .d(SHIFT_CLK), .q(sck_s));
   ldk_sync u_din (.clk(SYS_CLK), .d(DATA_IN), .q(din_s));
   genvar gk;
   generate
      for (gk = 0; gk < 3; gk++) begin : g_key
         ldk_sync u_k (.clk(SYS_CLK), .d(KEY_RETURN_LINES[gk]), .q(key_s[gk]));
      end
   endgenerate

   // ------------------------------------------------------------
   // edge detection on synchronised levels
   // ------------------------------------------------------------
   logic stb_d_r, sck_d_r;
   always_ff @(posedge SYS_CLK) begin
      stb_d_r <= stb_s;
      sck_d_r <= sck_s;
   end
   wire active = !stb_s; // clock edges count only inside a frame
   wire sck_rise = active && sck_s && !sck_d_r;
   wire sck_fall = active && !sck_s && sck_d_r;
   wire stb_fall = !stb_s && stb_d_r;

   // ------------------------------------------------------------
   // serial receiver
   // ------------------------------------------------------------
   logic [7:0] sh_r;
   logic [2:0] bit_r;
   logic first_r; // next byte is the command byte
   wire [7:0] byte_w = {din_s, sh_r[7:1]}; // lsb arrives first
   wire byte_done = sck_rise && (bit_r == 3'd7);
   // receiver restarts on every frame edge; partial bytes are dropped
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N || stb_s) begin
         bit_r <= 3'd0;
      end else if (sck_rise) begin
         sh_r <= byte_w;
         bit_r <= bit_r + 3'd1;
      end
   end
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N || stb_fall) begin
         first_r <= 1'b1;
      end else if (byte_done) begin
         first_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // command decode
   // ------------------------------------------------------------
   // command state, declared ahead of the decode that reads it
   logic [1:0] mode_r;
   logic [3:0] dset_r;
   logic [3:0] addr_r;
   logic on_r;
   logic [2:0] dim_r;
   logic reading_r;
   wire is_cmd = byte_done && first_r;
   wire is_data = byte_done && !first_r;
   wire c_mode = is_cmd && (byte_w[7:2] == 6'h00);
   wire c_dset = is_cmd && (byte_w[7:4] == 4'h4);
   wire c_addr = is_cmd && (byte_w[7:6] == CMD_ADDR);
   wire c_ctrl = is_cmd && (byte_w[7:6] == CMD_CTRL);
   wire [1:0] new_mode = (byte_w[1:0] == MODE_6GRID) ? MODE_6GRID : MODE_7GRID;
   wire mode_chg = c_mode && (new_mode != mode_r); // same mode is a no-op
   // a write lands only in write mode, outside a key read, at a valid address
   wire addr_ok = (addr_r <= ADDR_LAST);
   wire wr_ok = is_data && !reading_r && !dset_r[DSET_READ_BIT] && addr_ok;

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         mode_r <= MODE_RST;
         dset_r <= DSET_RST;
         addr_r <= ADDR_RST;
         on_r <= 1'b0;
         dim_r <= DIM_RST;
      end else begin
         if (mode_chg) begin
            mode_r <= new_mode;
            on_r <= 1'b0;
         end
         if (c_dset) begin
            dset_r <= byte_w[3:0];
         end
         if (c_addr) begin
            addr_r <= byte_w[3:0];
         end
         if (c_ctrl) begin
            on_r <= byte_w[DCTL_ON_BIT];
            dim_r <= byte_w[2:0];
         end
         // store then advance unless fixed address
         if (wr_ok && !dset_r[DSET_FIXED_BIT]) begin
            addr_r <= addr_r + 4'd1;
         end
      end
   end

   // ------------------------------------------------------------
   // display ram, 14 bytes, two per digit
   // ------------------------------------------------------------
   logic [7:0] ram_r [RAM_DEPTH];
   always_ff @(posedge SYS_CLK) begin
      if (wr_ok) begin
         ram_r[addr_r] <= byte_w;
      end
   end

   // ------------------------------------------------------------
   // scan: grid slots, dimming, key latch
   // ------------------------------------------------------------
   logic [9:0] slot_cnt_r;
   logic [2:0] grid_r;
   logic [3:0] pw_r;
   wire slot_end = (slot_cnt_r == 10'(SLOT_CYCLES - 1));
   wire pw_tick = (slot_cnt_r[5:0] == 6'h3f); // 16 sub-steps per slot
   wire cyc_end = slot_end && (grid_r == 3'(GRID_SLOTS - 1));
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         slot_cnt_r <= 10'h000;
         grid_r <= 3'h0;
         pw_r <= 4'h0;
      end else if (slot_end) begin
         slot_cnt_r <= 10'h000;
         grid_r <= grid_r + 3'd1;
         pw_r <= 4'h0;
      end else begin
         slot_cnt_r <= slot_cnt_r + 10'd1;
         if (pw_tick && pw_r != 4'hf) begin
            pw_r <= pw_r + 4'd1;
         end
      end
   end
   // step n lights for (2n+1)/16 of a slot
   wire lit = on_r && (pw_r <= {dim_r, 1'b0});
   wire six = (mode_r == MODE_6GRID);
   wire [2:0] ndig = six ? 3'd6 : 3'd7;
   wire dig_ok = (grid_r < ndig);
   wire [7:0] lo_b = dig_ok ? ram_r[{grid_r, 1'b0}] : 8'h00;
   wire [7:0] hi_b = dig_ok ? ram_r[{grid_r, 1'b1}] : 8'h00;

   // key storage: slot 7 is the key phase, one source per 64-cycle sub-step
   logic [2:0] kmem_r [KEY_SRC];
   wire key_phase = (grid_r == 3'h7);
   wire [3:0] kidx = slot_cnt_r[9:6] < 4'd10 ? slot_cnt_r[9:6] : 4'd9;
   logic [2:0] kcur_r [KEY_SRC];
   always_ff @(posedge SYS_CLK) begin
      if (key_phase && pw_tick) begin
         kcur_r[kidx] <= key_s;
      end
      if (cyc_end) begin
         kmem_r <= kcur_r;
      end
   end

   // drive outputs: segments and grids active high
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         SEGMENT_KEY_SOURCE_LINES <= 10'h000;
         SEGMENT_ELEVEN_LINE <= 1'b0;
         SHARED_SEGMENT_GRID_LINE <= 1'b0;
         GRID_DRIVE_LINES <= 6'h00;
      end else if (key_phase) begin
         // key scan keeps running even with the display off
         SEGMENT_KEY_SOURCE_LINES <= 10'(1) << kidx;
         SEGMENT_ELEVEN_LINE <= 1'b0;
         SHARED_SEGMENT_GRID_LINE <= 1'b0;
         GRID_DRIVE_LINES <= 6'h00;
      end else begin
         SEGMENT_KEY_SOURCE_LINES <= lit ? {hi_b[1:0], lo_b} : 10'h000;
         SEGMENT_ELEVEN_LINE <= lit && hi_b[2];
         SHARED_SEGMENT_GRID_LINE <= six ? (lit && hi_b[3])
                                         : (lit && grid_r == 3'd6);
         GRID_DRIVE_LINES <= (lit && grid_r < 3'd6) ? 6'(6'h01 << grid_r) : 6'h00;
      end
   end
   always_ff @(posedge SYS_CLK) begin
      DISPLAY_ON <= RST_N && on_r;
      SIX_GRID_MODE <= RST_N && six;
   end

   // ------------------------------------------------------------
   // key read-out
   // ------------------------------------------------------------
   logic [5:0] rd_bit_r; // bit index across the five key bytes
   wire [2:0] rb = rd_bit_r[2:0];
   wire [2:0] rbyte = rd_bit_r[5:3];
   wire [2:0] kb_lo = kmem_r[{rbyte, 1'b0}];
   wire [2:0] kb_hi = kmem_r[{rbyte, 1'b1}];
   wire [7:0] kbyte = (rbyte < 3'd5) ? {2'b00, kb_hi, kb_lo} : 8'h00;
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N || stb_s) begin
         reading_r <= 1'b0;
         rd_bit_r <= 6'h00;
         DATA_OUT_O <= 1'b0;
         DATA_OUT_OE <= 1'b0; // released: pull-up gives one
      end else begin
         if (c_dset && byte_w[DSET_READ_BIT]) begin
            reading_r <= 1'b1; // host observes the wait before clocking
         end
         if (reading_r && sck_fall) begin
            // change on falling edge, pull low only for a zero
            DATA_OUT_OE <= !kbyte[rb];
            // roll from b7 of one byte to b0 of the next
            rd_bit_r <= (rd_bit_r == 6'd39) ? 6'h00 : rd_bit_r + 6'd1;
         end
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   // steps named once: the last bit of the fifth key byte, a data setting command
   sequence s_last_key_bit;
      reading_r && sck_fall && (rd_bit_r == 6'd39);
   endsequence
   sequence s_dset_cmd;
      c_dset;
   endsequence
   chk_mode_reset: assert property (
      @(posedge SYS_CLK) $rose(RST_N) |-> mode_r == MODE_7GRID)
      else $error("mode not seven grid after reset");
   chk_dark_after_mode: assert property (
      @(posedge SYS_CLK) disable iff (!RST_N) mode_chg |=> !on_r)
      else $error("display lit after mode change");
   chk_same_mode: assert property (
      @(posedge SYS_CLK) disable iff (!RST_N)
      (c_mode && !mode_chg) |=> $stable(on_r) && $stable(mode_r))
      else $error("same mode changed state");
   chk_mode_set: assert property (
      @(posedge SYS_CLK) disable iff (!RST_N) mode_chg |=> mode_r == $past(new_mode))
      else $error("mode not taken");
   chk_no_bad_write: assert property (
      @(posedge SYS_CLK) disable iff (!RST_N) (is_data && !addr_ok) |=> $stable(addr_r))
      else $error("bad address moved");
   chk_addr_inc: assert property (
      @(posedge SYS_CLK) disable iff (!RST_N)
      (wr_ok && !dset_r[DSET_FIXED_BIT] && !c_addr) |=> addr_r == $past(addr_r) + 4'd1)
      else $error("address not advanced");
   chk_fixed_addr: assert property (
      @(posedge SYS_CLK) disable iff (!RST_N)
      (wr_ok && dset_r[DSET_FIXED_BIT]) |=> $stable(addr_r))
      else $error("fixed address moved");
   chk_dset_load: assert property (
      @(posedge SYS_CLK) disable iff (!RST_N) s_dset_cmd |=> dset_r == $past(byte_w[3:0]))
      else $error("data setting not taken");
   chk_ignore_high: assert property (
      @(posedge SYS_CLK) disable iff (!RST_N) stb_s |=> bit_r == 3'd0)
      else $error("clock counted outside frame");
   chk_dout_fall: assert property (
      @(posedge SYS_CLK) disable iff (!RST_N) (!stb_s && !sck_fall) |=> $stable(DATA_OUT_OE))
      else $error("output moved off edge");
   chk_key_roll: assert property (
      @(posedge SYS_CLK) disable iff (!RST_N) s_last_key_bit |=> rd_bit_r == 6'h00)
      else $error("key read did not wrap");
   chk_ctrl_on: assert property (
      @(posedge SYS_CLK) disable iff (!RST_N)
      c_ctrl |=> on_r == $past(byte_w[DCTL_ON_BIT]) && dim_r == $past(byte_w[2:0]))
      else $error("control not applied");
endmodule

/* dv/ldk_host.sv */
`timescale 1ns/100ps
// ---------------------------------------------
// host side of the strobe-framed serial link
// ---------------------------------------------
module ldk_host (
   output logic frame_select,
   output logic shift_clk,
   output logic data_in,
   input wire logic data_line
);
   // link idles with the frame closed and the shift clock parked high
   initial begin
      frame_select = 1'b1;
      shift_clk = 1'b1;
      data_in = 1'b0;
   end
   // open a frame: the first byte after this is taken as the command
   task automatic start();
      frame_select = 1'b0;
      #80;
   endtask
   // n bits lsb first, set after the falling edge and valid at the rising one;
   // the read bit is taken late in the high phase because the output lags
   task automatic put(input logic [7:0] v, input int n, output logic [7:0] r);
      r = 8'h00;
      for (int i = 0; i < n; i++) begin
         shift_clk = 1'b0;
         data_in = v[i];
         #80;
         shift_clk = 1'b1;
         #80;
         r[i] = data_line;
      end
   endtask
   // key reads need a gap after the command's eighth rising edge
   task automatic read_gap();
      #1000;
   endtask
   // close the frame; the data line carries nothing now, so scramble it
   task automatic stop();
      frame_select = 1'b1;
      data_in = ~data_in;
      #160;
   endtask
endmodule

/* dv/led_display_key_scan_ctrl_test.sv */
`timescale 1ns/100ps
// ---------------------------------------------
// self-checking bench: commands, partial frames, key reads
// ---------------------------------------------
module led_display_key_scan_ctrl_test;
   import ldk_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   wire frame_select, shift_clk, data_in, data_out_o, data_out_oe;
   wire data_line = data_out_oe ? data_out_o : 1'b1; // external pull-up
   logic [2:0] key_ret = 3'h0;
   logic [2:0] keys [10];
   logic [7:0] ram_m [RAM_DEPTH];
   wire [9:0] src;
   wire [5:0] grid;
   wire seg11, shared, disp_on, six;
   int n_mismatch = 0;
   int n_compared = 0;
   logic [31:0] rnd = 32'h67fd;
   logic [7:0] r;
   logic exp_six;
   ldk_ctrl DUT (.SYS_CLK(sys_clk), .RST_N(rst_n), .FRAME_SELECT(frame_select),
      .SHIFT_CLK(shift_clk), .DATA_IN(data_in), .DATA_OUT_O(data_out_o),
      .DATA_OUT_OE(data_out_oe), .KEY_RETURN_LINES(key_ret),
      .SEGMENT_KEY_SOURCE_LINES(src), .SEGMENT_ELEVEN_LINE(seg11),
      .SHARED_SEGMENT_GRID_LINE(shared), .GRID_DRIVE_LINES(grid),
      .DISPLAY_ON(disp_on), .SIX_GRID_MODE(six));
   ldk_host host (.frame_select(frame_select), .shift_clk(shift_clk),
      .data_in(data_in), .data_line(data_line));
   initial forever #10 sys_clk = ~sys_clk;
   // key matrix: a pressed key ties its source line to its return line
   always @(posedge sys_clk) begin
      #1;
      key_ret = 3'h0;
      for (int i = 0; i < KEY_SRC; i++) if (src[i] === 1'b1) key_ret |= keys[i];
   end
   function automatic logic [31:0] step(input logic [31:0] x);
      return x[0] ? ((x >> 1) ^ 32'h80200003) : (x >> 1);
   endfunction
   // b6..b7 carry nothing, so only six bits are predicted
   function automatic logic [5:0] kbyte(input int n);
      return {keys[2 * n + 1], keys[2 * n]};
   endfunction
   // digit d: byte 2d on segments 1-8, low bits of 2d+1 above; shared line is grid 7
   function automatic logic [11:0] seg_exp(input int d);
      return {d == 6, ram_m[2 * d + 1][2:0], ram_m[2 * d]};
   endfunction
   task automatic chk_seg(input logic [11:0] got, input logic [11:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_flag(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_byte(input logic [5:0] got, input logic [5:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmd(input logic [7:0] v);
      host.start();
      host.put(v, 8, r);
      host.stop();
   endtask
   task automatic report_and_stop();
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // watchdog sized for one scan pass and two key rounds of two display cycles, with margin
   initial begin
      #1600000;
      n_mismatch++;
      report_and_stop();
   end
   initial begin
      for (int i = 0; i < KEY_SRC; i++) keys[i] = 3'h0;
      repeat (2) @(posedge sys_clk); // reset held for two cycles
      #1 rst_n = 1'b1;
      repeat (4) @(posedge sys_clk);
      #1;
      chk_flag(disp_on, 1'b0);
      chk_flag(six, 1'b0);
      cmd(8'h8f);
      chk_flag(disp_on, 1'b1);
      host.start();
      host.put(8'h02, 5, r);
      host.stop();
      chk_flag(six, 1'b0);
      host.put(8'h02, 8, r);
      chk_flag(six, 1'b0);
      // every mode code after switching on; a real change darkens the display
      exp_six = 1'b0;
      for (int i = 0; i < 8; i++) begin
         cmd(8'h88 | i[7:0]);
         chk_flag(disp_on, 1'b1);
         cmd({6'h00, i[1:0]});
         chk_flag(disp_on, (i[1:0] == MODE_6GRID) == exp_six);
         exp_six = (i[1:0] == MODE_6GRID);
         chk_flag(six, exp_six);
      end
      // fill all 14 places, then aim at an address past the end
      cmd(8'h40);
      host.start();
      host.put(8'hc0, 8, r);
      for (int i = 0; i < RAM_DEPTH; i++) begin
         rnd = step(rnd);
         host.put(rnd[7:0], 8, r);
         ram_m[i] = rnd[7:0];
      end
      host.stop();
      host.start();
      host.put(8'hce, 8, r);
      host.put(rnd[15:8], 8, r);
      host.stop();
      cmd(8'h44);
      // fixed address: both bytes land on 03h, so only the second one stays
      host.start();
      host.put(8'hc3, 8, r);
      host.put(rnd[23:16], 8, r);
      host.put(rnd[31:24], 8, r);
      host.stop();
      ram_m[3] = rnd[31:24];
      // light the display and catch each of the seven digits while it is driven
      cmd(8'h8f);
      for (int d = 0; d < 7; d++) begin
         while ((d < 6) ? (grid !== 6'(6'h01 << d)) : (shared !== 1'b1)) begin
            @(posedge sys_clk);
            #1;
         end
         chk_seg({shared, seg11, src}, seg_exp(d));
      end
      // two rounds of random key patterns, six bytes read to see the wrap
      for (int k = 0; k < 2; k++) begin
         for (int i = 0; i < KEY_SRC; i++) begin
            rnd = step(rnd);
            keys[i] = rnd[2:0];
         end
         repeat (2 * GRID_SLOTS * SLOT_CYCLES) @(posedge sys_clk);
         #1;
         host.start();
         host.put(8'h42, 8, r);
         host.read_gap();
         for (int j = 0; j < 6; j++) begin
            host.put(rnd[7:0] ^ j[7:0], 8, r);
            chk_byte(r[5:0], kbyte(j % KEY_BYTES));
         end
         host.stop();
         chk_flag(data_out_oe, 1'b0);
      end
      report_and_stop();
   end
endmodule
